//--- rtl/sct_log_defs.svh
`ifndef SCT_LOG_DEFS_SVH
`define SCT_LOG_DEFS_SVH

// Register byte addresses
`define OFF_CTRL 8'h00
`define OFF_CMD 8'h04
`define OFF_STAT 8'h08
`define OFF_PTR 8'h0C
`define OFF_DATA 8'h10
`define OFF_IDENT 8'h14

// Control register bits and reset value
`define CTRL_SMART_EN 0
`define CTRL_SEC_LOCK 1
`define CTRL_REBUILD_SUP 2
`define CTRL_RESET 3'h4

// Command register fields
`define CMD_TERM_BIT 31
`define CMD_FIELD_W 10

// Log page addresses
`define PAGE_REBUILD 8'h15
`define PAGE_SCT_CMD 8'hE0
`define PAGE_SCT_DATA 8'hE1

// Sector geometry
`define SECTOR_WORDS 128
`define LAST_WORD 7'h7F

// Rebuild log layout (N bytes of mask and N bytes of elements)
`define ELEM_BYTES 8'h04
`define ELEM_MASK 32'hFFFFFFFF
`define RB_WORD_FLAGS 7'h00
`define RB_WORD_LEN 7'h01
`define RB_WORD_MASK 7'h02
`define RB_WORD_ELEMS 7'h03

// Identify word 206 fields
`define ID206_VENDOR 4'h0
`define ID206_ACTIONS 4'hF
`define ACT_MIN 16'h0002
`define ACT_MAX 16'h0005

// Extended status codes
`define EXT_OK 16'h0000
`define EXT_LOCKED 16'h0001
`define EXT_BAD_ACTION 16'h0002
`define EXT_NESTED 16'h0003
`define EXT_NO_XFER 16'h0004
`define EXT_BAD_PAGE 16'h0005
`define EXT_SMART_OFF 16'h0006

`endif

//--- rtl/sct_log_pkg.sv
package sct_log_pkg;

	typedef enum logic {ST_IDLE, ST_RUN} state_type;

	typedef enum logic [1:0] {JOB_REBUILD, JOB_STATUS, JOB_DATA_OUT, JOB_DATA_IN} job_type;

	typedef struct packed {
		logic ext;
		logic write;
		logic [7:0] page;
	} log_cmd_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_type;

endpackage : sct_log_pkg

//--- rtl/sct_log_page_transport.sv
// Behaviour
// [R01] Rebuild support implies rebuild log page present
// [R02] Rebuild log: flag, length, mask, elements
// [R03] Length equals mask and element byte counts
// [R04] Host writes never change length or mask
// [R05] Mask bits mark supported element bits
// [R06] Disabled element set: predicted errors
// [R07] Disabled element clear: no predicted errors
// [R08] Page E0h: write issues, read returns status
// [R09] Page E1h: write sends, read returns data
// [R10] SMART and extended log commands equivalent; the code rejects SMART commands to non-SCT pages while SMART is disabled
// [R11] Directory length one, not transfer size
// [R12] SCT pages reachable while SMART disabled
// [R13] Security locked: every SCT command fails
// [R14] Word 206 reports SCT capability bits
// [R15] Host finishes data before next command
// [R16] Standard commands may intermix with transfers
// [R17] Any reset terminates executing SCT command
// [R18] No trace of terminated command afterwards
// [R19] Key sector carries action, function, parameters
// [R20] Latest command status stays readable
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "sct_log_defs.svh"

module sct_log_page_transport
	import sct_log_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire bus_req_type busReq,
	output logic [31:0] readData,
	input wire logic [4:0] elemSel,
	output logic elemPredicted,
	output logic busy
);

	logic [31:0] bufMem [0:`SECTOR_WORDS-1];
	logic [31:0] dataMem [0:`SECTOR_WORDS-1];

	logic smartEnabled;
	logic secLocked;
	logic rebuildSupport;
	logic rebuildEnabled;
	logic [31:0] disabledElems;

	state_type state;
	job_type job;
	logic [6:0] idx;
	logic [6:0] ptr;

	logic cmdOk;
	logic cmdErr;
	logic [15:0] extStatus;
	logic [15:0] lastAction;
	logic [15:0] lastFunction;
	logic [15:0] pendingSectors;

	logic cmdWrite;
	logic termReq;
	logic newCmd;
	log_cmd_type cmd;
	logic sctPage;
	logic smartBlocked;
	logic [15:0] keyAction;
	logic [15:0] keyFunction;
	logic [15:0] keySectors;
	logic [15:0] word206;
	logic actionSupported;
	logic jobDone;
	logic [31:0] fillWord;

	logic reject;
	logic [15:0] verdictCode;
	logic startJob;
	job_type jobSel;
	logic keyAccept;
	logic rebuildWrite;

	function automatic logic [31:0] byteSwap(input logic [31:0] w);
		byteSwap = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : byteSwap

	assign cmdWrite = busReq.wr && (busReq.addr == `OFF_CMD);
	assign termReq = cmdWrite && busReq.wdata[`CMD_TERM_BIT];
	assign newCmd = cmdWrite && !busReq.wdata[`CMD_TERM_BIT] && (state == ST_IDLE);
	assign cmd = log_cmd_type'(busReq.wdata[`CMD_FIELD_W-1:0]);
	assign busy = (state == ST_RUN);

	// SCT pages bypass the SMART enable; other pages over SMART need it
	assign sctPage = (cmd.page == `PAGE_SCT_CMD) || (cmd.page == `PAGE_SCT_DATA); // R12
	assign smartBlocked = !cmd.ext && !smartEnabled && !sctPage; // R10

	// Key sector: word 0 action and function, word 1 data sectors, rest parameters
	assign keyAction = bufMem[0][15:0]; // R19
	assign keyFunction = bufMem[0][31:16]; // R19
	assign keySectors = bufMem[1][15:0]; // R19

	assign word206 = {`ID206_VENDOR, 6'h00, `ID206_ACTIONS, 1'b0, 1'b1}; // R14
	assign actionSupported = (keyAction >= `ACT_MIN) && (keyAction <= `ACT_MAX) && word206[keyAction[3:0]];

	assign jobDone = (state == ST_RUN) && (idx == `LAST_WORD);

	// Verdict on a new log command
	always_comb begin
		reject = 1'b0;
		verdictCode = `EXT_OK;
		startJob = 1'b0;
		jobSel = JOB_STATUS;
		keyAccept = 1'b0;
		rebuildWrite = 1'b0;
		if (smartBlocked) begin
			reject = 1'b1;
			verdictCode = `EXT_SMART_OFF;
		end else begin
			case (cmd.page)
				`PAGE_REBUILD: begin
					if (!rebuildSupport) begin
						reject = 1'b1;
						verdictCode = `EXT_BAD_PAGE;
					end else if (cmd.write) begin
						rebuildWrite = 1'b1;
					end else begin
						startJob = 1'b1; // R01
						jobSel = JOB_REBUILD;
					end
				end
				`PAGE_SCT_CMD: begin
					if (!cmd.write) begin
						startJob = 1'b1; // R08
						jobSel = JOB_STATUS;
					end else if (secLocked) begin
						reject = 1'b1; // R13
						verdictCode = `EXT_LOCKED;
					end else if (pendingSectors != 16'h0000) begin
						reject = 1'b1; // R15
						verdictCode = `EXT_NESTED;
					end else if (!actionSupported) begin
						reject = 1'b1;
						verdictCode = `EXT_BAD_ACTION;
					end else begin
						keyAccept = 1'b1; // R08
					end
				end
				`PAGE_SCT_DATA: begin
					if (secLocked) begin
						reject = 1'b1; // R13
						verdictCode = `EXT_LOCKED;
					end else if (pendingSectors == 16'h0000) begin
						reject = 1'b1;
						verdictCode = `EXT_NO_XFER;
					end else begin
						startJob = 1'b1; // R09
						jobSel = cmd.write ? JOB_DATA_IN : JOB_DATA_OUT;
					end
				end
				default: begin
					reject = 1'b1;
					verdictCode = `EXT_BAD_PAGE;
				end
			endcase
		end
	end

	// Words produced by the engine when a page is read
	always_comb begin
		fillWord = 32'h00000000;
		case (job)
			JOB_REBUILD: begin
				case (idx)
					`RB_WORD_FLAGS: fillWord = {31'h00000000, rebuildEnabled}; // R02
					`RB_WORD_LEN: fillWord = {`ELEM_BYTES, 24'h000000}; // R03
					`RB_WORD_MASK: fillWord = byteSwap(`ELEM_MASK); // R02
					`RB_WORD_ELEMS: fillWord = byteSwap(disabledElems); // R02
					default: fillWord = 32'h00000000;
				endcase
			end
			JOB_STATUS: begin
				case (idx)
					7'h00: fillWord = {extStatus, lastAction}; // R20
					7'h01: fillWord = {pendingSectors, lastFunction}; // R20
					7'h02: fillWord = {29'h00000000, pendingSectors != 16'h0000, cmdErr, cmdOk};
					default: fillWord = 32'h00000000;
				endcase
			end
			JOB_DATA_OUT: fillWord = dataMem[idx]; // R09
			default: fillWord = 32'h00000000;
		endcase
	end

	// Control bits
	always_ff @(posedge clk) begin
		if (rst) begin
			smartEnabled <= 1'b0;
			secLocked <= 1'b0;
			rebuildSupport <= 1'b1;
		end else if (busReq.wr && (busReq.addr == `OFF_CTRL)) begin
			smartEnabled <= busReq.wdata[`CTRL_SMART_EN];
			secLocked <= busReq.wdata[`CTRL_SEC_LOCK];
			rebuildSupport <= busReq.wdata[`CTRL_REBUILD_SUP];
		end
	end

	// Rebuild log state; length and mask are constants the host cannot touch
	always_ff @(posedge clk) begin
		if (rst) begin
			rebuildEnabled <= 1'b0;
			disabledElems <= 32'h00000000;
		end else if (newCmd && rebuildWrite) begin
			rebuildEnabled <= bufMem[`RB_WORD_FLAGS][0];
			disabledElems <= byteSwap(bufMem[`RB_WORD_ELEMS]) & `ELEM_MASK; // R04 R05
		end
	end

	// Predicted-error answer for the selected physical element
	always_ff @(posedge clk) begin
		if (rst) begin
			elemPredicted <= 1'b0;
		end else begin
			elemPredicted <= disabledElems[elemSel]; // R06 R07
		end
	end

	// Page engine
	always_ff @(posedge clk) begin
		if (rst || termReq) begin
			state <= ST_IDLE; // R17
			job <= JOB_STATUS;
			idx <= 7'h00;
		end else begin
			case (state)
				ST_IDLE: begin
					if (newCmd && startJob) begin
						state <= ST_RUN;
						job <= jobSel;
						idx <= 7'h00;
					end
				end
				ST_RUN: begin
					idx <= idx + 7'h01;
					if (jobDone) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// SCT command state; a termination leaves nothing behind
	always_ff @(posedge clk) begin
		if (rst || termReq) begin
			lastAction <= 16'h0000; // R18
			lastFunction <= 16'h0000;
			pendingSectors <= 16'h0000; // R17
		end else if (newCmd && keyAccept) begin
			lastAction <= keyAction; // R19
			lastFunction <= keyFunction;
			pendingSectors <= keySectors;
		end else if (jobDone && ((job == JOB_DATA_IN) || (job == JOB_DATA_OUT))) begin
			// One sector per log command; the page length plays no part
			pendingSectors <= pendingSectors - 16'h0001; // R11
		end
	end

	// Result of the most recent log command other than a page E0h read
	always_ff @(posedge clk) begin
		if (rst || termReq) begin
			cmdOk <= 1'b0; // R18
			cmdErr <= 1'b0;
			extStatus <= `EXT_OK;
		end else if (newCmd && reject) begin
			cmdOk <= 1'b0;
			cmdErr <= 1'b1;
			extStatus <= verdictCode; // R13 R20
		end else if (newCmd && (keyAccept || rebuildWrite)) begin
			cmdOk <= 1'b1;
			cmdErr <= 1'b0;
			extStatus <= `EXT_OK; // R20
		end else if (jobDone && (job != JOB_STATUS)) begin
			cmdOk <= 1'b1;
			cmdErr <= 1'b0;
			extStatus <= `EXT_OK;
		end
	end

	// Sector pointer, auto-incremented by data port accesses while idle
	always_ff @(posedge clk) begin
		if (rst) begin
			ptr <= 7'h00;
		end else if (busReq.wr && (busReq.addr == `OFF_PTR)) begin
			ptr <= busReq.wdata[6:0];
		end else if ((busReq.wr || busReq.rd) && (busReq.addr == `OFF_DATA) && !busy) begin
			ptr <= ptr + 7'h01;
		end
	end

	// Sector buffer: filled by software or by the engine when a page is read
	always_ff @(posedge clk) begin
		if ((state == ST_RUN) && (job != JOB_DATA_IN)) begin
			bufMem[idx] <= fillWord;
		end else if (busReq.wr && (busReq.addr == `OFF_DATA) && !busy) begin
			bufMem[ptr] <= busReq.wdata;
		end
	end

	// Drive-side SCT data; standard traffic between transfers never disturbs it
	always_ff @(posedge clk) begin
		if ((state == ST_RUN) && (job == JOB_DATA_IN)) begin
			dataMem[idx] <= bufMem[idx]; // R09 R16
		end
	end

	// Read data stands for exactly one cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst || !busReq.rd) begin
			readData <= 32'h00000000;
		end else begin
			case (busReq.addr)
				`OFF_CTRL: readData <= {29'h00000000, rebuildSupport, secLocked, smartEnabled};
				`OFF_CMD: readData <= 32'h00000000;
				`OFF_STAT: readData <= {extStatus, 12'h000, pendingSectors != 16'h0000, cmdErr, cmdOk, busy};
				`OFF_PTR: readData <= {25'h0000000, ptr};
				`OFF_DATA: readData <= bufMem[ptr];
				`OFF_IDENT: readData <= {15'h0000, rebuildSupport, word206}; // R01 R14
				default: readData <= 32'h00000000;
			endcase
		end
	end

endmodule : sct_log_page_transport

//--- verif/sct_log_page_transport_assertions.sv
`timescale 1ns/1ps
module sct_log_page_transport_assertions
	import sct_log_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire bus_req_type busReq,
	input wire logic [31:0] readData,
	input wire logic [4:0] elemSel,
	input wire logic elemPredicted,
	input wire logic busy
);
	logic [7:0] busyCnt;
	logic sup;
	logic termW;
	logic cmdW;
	assign termW = busReq.wr && busReq.addr == 8'h04 && busReq.wdata[31];
	assign cmdW = busReq.wr && busReq.addr == 8'h04 && !busReq.wdata[31];
	always_ff @(posedge clk) begin
		if (rst || !busy) begin
			busyCnt <= 8'h00;
		end else begin
			busyCnt <= busyCnt + 8'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			sup <= 1'b1;
		end else if (busReq.wr && busReq.addr == 8'h00) begin
			sup <= busReq.wdata[2];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_stat;
		busReq.rd && busReq.addr == 8'h08;
	endsequence
	sequence s_quiet;
		(!busReq.wr && !busy && $stable(elemSel))[*4];
	endsequence
	AST_IDENT: assert property (busReq.rd && busReq.addr == 8'h14 |=> readData[15:0] == 16'h003D)
		else $error("identify word wrong");
	AST_REBUILD_SUP: assert property (busReq.rd && busReq.addr == 8'h14 |=> readData[16] == sup)
		else $error("rebuild support bit wrong");
	AST_ELEM_HOLD: assert property (s_quiet |=> $stable(elemPredicted))
		else $error("element flag moved");
	AST_TERM_IDLE: assert property (termW |=> !busy)
		else $error("busy after terminate");
	AST_TERM_CLEAN: assert property (termW ##2 s_stat |=> readData == 32'h0)
		else $error("status left after terminate");
	AST_STAT_SET: assert property (cmdW && !busy ##2 s_stat |=> readData[2:0] != 3'b000)
		else $error("no status after command");
	AST_BUSY_LEN: assert property (busy && busyCnt == 8'h7F |=> !busy)
		else $error("engine too long");
	AST_BUSY_FULL: assert property ($fell(busy) |-> $past(busyCnt) == 8'h7F || $past(termW) || $past(rst))
		else $error("engine too short");
endmodule : sct_log_page_transport_assertions
bind sct_log_page_transport sct_log_page_transport_assertions sct_log_page_transport_assertions_inst (
	.clk(clk), .rst(rst), .busReq(busReq), .readData(readData),
	.elemSel(elemSel), .elemPredicted(elemPredicted), .busy(busy)
);

//--- verif/log_host.sv
`timescale 1ns/1ps
module log_host
	import sct_log_pkg::*;
(
	input wire logic clk,
	input wire logic [31:0] readData,
	output bus_req_type busReq
);
	initial busReq = '0;
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		busReq <= '{~a, ~d, 1'b0, 1'b0};
	endtask : put
	task automatic get(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		busReq <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		busReq <= '{~a, 32'hA5A5A5A5, 1'b0, 1'b0};
		#1;
		d = readData;
	endtask : get
endmodule : log_host

//--- verif/sct_log_page_transport_test.sv
`timescale 1ns/1ps
module sct_log_page_transport_test
	import sct_log_pkg::*;
;
	logic clk;
	logic rst;
	logic [4:0] elemSel;
	logic [31:0] readData;
	logic elemPredicted;
	logic busy;
	bus_req_type busReq;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;
	log_host log_host_inst (.clk(clk), .readData(readData), .busReq(busReq));
	sct_log_page_transport sct_log_page_transport_inst (.clk(clk), .rst(rst), .busReq(busReq),
		.readData(readData), .elemSel(elemSel), .elemPredicted(elemPredicted), .busy(busy));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		log_host_inst.put(a, d);
	endtask : wr
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		log_host_inst.get(a, d);
		chk(n, e, d);
	endtask : rd
	task automatic settle();
		int n;
		n = 0;
		#1;
		while (busy !== 1'b0 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("busy", 32'h0, {31'h0, busy});
	endtask : settle
	task automatic key(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] st);
		wr(8'h0C, 32'h0);
		wr(8'h10, w0);
		wr(8'h10, w1);
		wr(8'h04, 32'h1E0);
		rd("stat", 8'h08, st);
	endtask : key
	task automatic elem(input logic [4:0] s, input logic e);
		@(posedge clk);
		elemSel <= s;
		repeat (2) @(posedge clk);
		#1;
		chk("elem", {31'h0, e}, {31'h0, elemPredicted});
	endtask : elem
	task automatic t_ident();
		rd("ident", 8'h14, 32'h0001003D);
		wr(8'h00, 32'h0);
		rd("ident", 8'h14, 32'h0000003D);
		wr(8'h00, 32'h4);
		rd("unmapped", 8'h40, 32'h0);
	endtask : t_ident
	task automatic t_rebuild();
		wr(8'h0C, 32'h0);
		wr(8'h10, 32'h1);
		wr(8'h10, 32'hFF000000);
		wr(8'h10, 32'h0);
		wr(8'h10, 32'h01000080);
		wr(8'h04, 32'h315);
		elem(5'd31, 1'b1);
		elem(5'd30, 1'b0);
		elem(5'd0, 1'b1);
		wr(8'h04, 32'h215);
		settle();
		wr(8'h0C, 32'h0);
		rd("rb0", 8'h10, 32'h1);
		rd("rb1", 8'h10, 32'h04000000);
		rd("rb2", 8'h10, 32'hFFFFFFFF);
		rd("rb3", 8'h10, 32'h01000080);
	endtask : t_rebuild
	task automatic t_sct();
		for (int a = 2; a <= 5; a++) begin
			key(32'(a), 32'h0, 32'h2);
		end
		key(32'h6, 32'h0, 32'h00020004);
		key(32'h00010005, 32'h1, 32'hA);
		key(32'h00010005, 32'h1, 32'h0003000C);
		wr(8'h04, 32'h3E1);
		settle();
		rd("stat", 8'h08, 32'h2);
		wr(8'h04, 32'h0E0);
		settle();
		wr(8'h0C, 32'h0);
		rd("status", 8'h10, 32'h5);
		wr(8'h04, 32'h1E1);
		rd("stat", 8'h08, 32'h00040004);
	endtask : t_sct
	task automatic t_lock();
		wr(8'h00, 32'h6);
		key(32'h00010005, 32'h0, 32'h00010004);
		wr(8'h00, 32'h4);
	endtask : t_lock
	task automatic t_term();
		wr(8'h04, 32'h2E0);
		repeat (5) @(posedge clk);
		wr(8'h04, 32'h80000000);
		#1;
		chk("busy", 32'h0, {31'h0, busy});
		rd("stat", 8'h08, 32'h0);
	endtask : t_term
	// Two-sector transfer: data in over SMART, another log command between, data out over extended
	task automatic t_xfer();
		key(32'h00010005, 32'h2, 32'hA);
		wr(8'h0C, 32'h0);
		wr(8'h10, 32'hC3A50F1E);
		wr(8'h04, 32'h1E1);
		settle();
		wr(8'h04, 32'h215);
		settle();
		wr(8'h04, 32'h2E1);
		settle();
		wr(8'h0C, 32'h0);
		rd("data", 8'h10, 32'hC3A50F1E);
		rd("stat", 8'h08, 32'h2);
	endtask : t_xfer
	// Reset pulse in the middle of a running job after an accepted key
	task automatic t_reset();
		key(32'h00010005, 32'h1, 32'hA);
		wr(8'h04, 32'h2E0);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk("busy", 32'h0, {31'h0, busy});
		rd("stat", 8'h08, 32'h0);
		elem(5'h1F, 1'b0);
	endtask : t_reset
	initial begin
		rst = 1'b1;
		elemSel = 5'd0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_ident();
		t_rebuild();
		t_sct();
		t_xfer();
		t_lock();
		t_term();
		t_reset();
		close_out();
	end
endmodule : sct_log_page_transport_test
